// [verilog/supv_cfg.svh]
`ifndef SUPV_CFG_SVH
`define SUPV_CFG_SVH

`define SUPV_CLK_MHZ        200
`define SUPV_CYC_PER_MS     (`SUPV_CLK_MHZ * 1000)
`define SUPV_RELEASE_MS     200
`define SUPV_POWERUP_MS     250
`define SUPV_WDOG_LONG_MS   1400
`define SUPV_WDOG_MID_MS    600
`define SUPV_WDOG_SHORT_MS  200
`define SUPV_NV_WRITE_MS    5
`define SUPV_RELEASE_CYC    (`SUPV_RELEASE_MS * `SUPV_CYC_PER_MS)
`define SUPV_POWERUP_CYC    (`SUPV_POWERUP_MS * `SUPV_CYC_PER_MS)
`define SUPV_WDOG_LONG_CYC  (`SUPV_WDOG_LONG_MS * `SUPV_CYC_PER_MS)
`define SUPV_WDOG_MID_CYC   (`SUPV_WDOG_MID_MS * `SUPV_CYC_PER_MS)
`define SUPV_WDOG_SHORT_CYC (`SUPV_WDOG_SHORT_MS * `SUPV_CYC_PER_MS)
`define SUPV_NV_WRITE_CYC   (`SUPV_NV_WRITE_MS * `SUPV_CYC_PER_MS)

// Control byte field positions
`define SUPV_CTRL_LOCK_BIT  7
`define SUPV_CTRL_SEL_HI    6
`define SUPV_CTRL_SEL_LO    5
// Factory value: lock off, watchdog disabled
`define SUPV_CTRL_RST_LOCK  1'b0
`define SUPV_CTRL_RST_SEL   2'b11
`define SUPV_SEL_LONG       2'b00
`define SUPV_SEL_MID        2'b01
`define SUPV_SEL_SHORT      2'b10
`define SUPV_SEL_OFF        2'b11

`endif

// [verilog/supv_pkg.sv]
package supv_pkg;

   typedef enum logic [1:0] {
      ST_POWERUP = 2'b00,
      ST_LOWSUP  = 2'b01,
      ST_WDOG    = 2'b10,
      ST_RUN     = 2'b11
   } supv_state_t;

   typedef struct packed {
      logic protect_lock_enable_bit;
      logic wdog_period_sel_hi;
      logic wdog_period_sel_lo;
   } ctrl_nv_t;

   typedef struct packed {
      logic sda;
      logic scl;
   } bus_pins_t;

endpackage

// [verilog/bus_start_detect.sv]
`timescale 1ns/10ps
module bus_start_detect
   import supv_pkg::*;
(
   input  wire logic      link_clk_i,
   input  wire logic      rstn_i,
   input  wire bus_pins_t pins_i,
   output logic           start_tgl_o
);

   bus_pins_t meta_r;
   bus_pins_t sync_r;
   bus_pins_t prev_r;
   logic      start_tgl_r;

   // Pin synchroniser
   always_ff @(posedge link_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_r <= '1;
         sync_r <= '1;
      end else begin
         meta_r <= pins_i;
         sync_r <= meta_r;
      end
   end

   always_ff @(posedge link_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prev_r <= '1;
      end else begin
         prev_r <= sync_r;
      end
   end

   always_ff @(posedge link_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         start_tgl_r <= 1'b0;
      end else if (prev_r.sda && !sync_r.sda && prev_r.scl && sync_r.scl) begin
         start_tgl_r <= ~start_tgl_r;
      end
   end

   assign start_tgl_o = start_tgl_r;

endmodule

// [verilog/supply_supervisor_watchdog_reset.sv]
`timescale 1ns/10ps
`include "supv_cfg.svh"
module supply_supervisor_watchdog_reset
   import supv_pkg::*;
#(
   parameter bit          RESET_ACTIVE_HIGH = 1'b0,
   parameter logic [31:0] RELEASE_CYC       = `SUPV_RELEASE_CYC,
   parameter logic [31:0] POWERUP_CYC       = `SUPV_POWERUP_CYC,
   parameter logic [31:0] WDOG_LONG_CYC     = `SUPV_WDOG_LONG_CYC,
   parameter logic [31:0] WDOG_MID_CYC      = `SUPV_WDOG_MID_CYC,
   parameter logic [31:0] WDOG_SHORT_CYC    = `SUPV_WDOG_SHORT_CYC,
   parameter logic [31:0] NV_WRITE_CYC      = `SUPV_NV_WRITE_CYC
)
(
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic       link_clk_i,
   input  wire logic       sda_i,
   input  wire logic       scl_i,
   input  wire logic       supply_low_i,
   input  wire logic       wp_i,
   input  wire logic       ctrl_wr_i,
   input  wire logic [7:0] ctrl_wdata_i,
   input  wire logic       nv_req_i,
   output logic            rst_pin_o,
   output logic            rst_pin_oe_o,
   output logic            bus_enable_o,
   output logic            bus_abort_o,
   output logic            ctrl_wr_ack_o,
   output logic            nv_start_o,
   output logic            nv_busy_o,
   output logic [7:0]      ctrl_rdata_o,
   output logic [1:0]      state_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations

   supv_state_t state_r;
   supv_state_t state_nxt;
   logic [31:0] dly_r;
   logic [31:0] dly_nxt;
   logic [31:0] wd_cnt_r;
   logic [31:0] nv_cnt_r;
   ctrl_nv_t    ctrl_r;
   logic        sup_meta_r;
   logic        sup_low_r;
   logic        wp_meta_r;
   logic        wp_r;
   logic        tgl_meta_r;
   logic        tgl_sync_r;
   logic        tgl_prev_r;
   logic        start_tgl;
   logic        start_evt;
   logic        hold;
   logic        wd_enabled;
   logic        wd_expire;
   logic        nv_busy_r;
   logic        ctrl_take;
   logic        nv_take;
   logic        oe_r;
   logic        abort_r;
   logic        ack_r;
   logic        nv_start_r;
   bus_pins_t   pins;

   ////////////////////////////////////////////////////////////////////////////////
   // Functions

   function automatic logic [31:0] wdog_limit(input logic [1:0] sel);
      case (sel)
         `SUPV_SEL_LONG:  wdog_limit = WDOG_LONG_CYC;
         `SUPV_SEL_MID:   wdog_limit = WDOG_MID_CYC;
         `SUPV_SEL_SHORT: wdog_limit = WDOG_SHORT_CYC;
         default:         wdog_limit = 32'hffff_ffff;
      endcase
   endfunction

   function automatic logic last_cycle(input logic [31:0] cnt, input logic [31:0] lim);
      last_cycle = (cnt >= lim - 32'h0000_0001);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Link side start detection

   assign pins.sda = sda_i;
   assign pins.scl = scl_i;

   bus_start_detect u_start (
      .link_clk_i  (link_clk_i),
      .rstn_i      (rstn_i),
      .pins_i      (pins),
      .start_tgl_o (start_tgl)
   );

   // Toggle crossing into the system clock
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tgl_meta_r <= 1'b0;
         tgl_sync_r <= 1'b0;
         tgl_prev_r <= 1'b0;
      end else begin
         tgl_meta_r <= start_tgl;
         tgl_sync_r <= tgl_meta_r;
         tgl_prev_r <= tgl_sync_r;
      end
   end

   assign start_evt = tgl_sync_r ^ tgl_prev_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sup_meta_r <= 1'b1;
         sup_low_r  <= 1'b1;
      end else begin
         sup_meta_r <= supply_low_i;
         sup_low_r  <= sup_meta_r;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wp_meta_r <= 1'b1;
         wp_r      <= 1'b1;
      end else begin
         wp_meta_r <= wp_i;
         wp_r      <= wp_meta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reset state machine

   assign hold       = (state_r != ST_RUN);
   assign wd_enabled = ({ctrl_r.wdog_period_sel_hi, ctrl_r.wdog_period_sel_lo}
                        != `SUPV_SEL_OFF);
   assign wd_expire  = wd_enabled && !start_evt
                       && last_cycle(wd_cnt_r, wdog_limit({ctrl_r.wdog_period_sel_hi,
                                                           ctrl_r.wdog_period_sel_lo}));

   always_comb begin
      state_nxt = state_r;
      dly_nxt   = dly_r;
      case (state_r)
         ST_POWERUP: begin
            if (sup_low_r) begin
               dly_nxt = 32'h0000_0000;
            end else if (last_cycle(dly_r, POWERUP_CYC)) begin
               state_nxt = ST_RUN;
               dly_nxt   = 32'h0000_0000;
            end else begin
               dly_nxt = dly_r + 32'h0000_0001;
            end
         end
         ST_LOWSUP, ST_WDOG: begin
            // a dip restarts the release delay
            if (sup_low_r) begin
               state_nxt = ST_LOWSUP;
               dly_nxt   = 32'h0000_0000;
            end else if (last_cycle(dly_r, RELEASE_CYC)) begin
               state_nxt = ST_RUN;
               dly_nxt   = 32'h0000_0000;
            end else begin
               dly_nxt = dly_r + 32'h0000_0001;
            end
         end
         ST_RUN: begin
            dly_nxt = 32'h0000_0000;
            if (sup_low_r) begin
               state_nxt = ST_LOWSUP;
            end else if (wd_expire) begin
               state_nxt = ST_WDOG;
            end
         end
         default: begin
            state_nxt = ST_POWERUP;
            dly_nxt   = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_r <= ST_POWERUP;
         dly_r   <= 32'h0000_0000;
      end else begin
         state_r <= state_nxt;
         dly_r   <= dly_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog counter

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wd_cnt_r <= 32'h0000_0000;
      end else if (hold || start_evt || !wd_enabled || state_nxt != ST_RUN) begin
         wd_cnt_r <= 32'h0000_0000;
      end else if (wd_cnt_r != 32'hffff_ffff) begin
         wd_cnt_r <= wd_cnt_r + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control field and nonvolatile write timing

   // blocked while pin high and lock set
   assign ctrl_take = ctrl_wr_i && !hold && !nv_busy_r
                      && !(wp_r && ctrl_r.protect_lock_enable_bit);
   assign nv_take   = nv_req_i && !ctrl_wr_i && !hold && !nv_busy_r;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_r.protect_lock_enable_bit <= `SUPV_CTRL_RST_LOCK;
         {ctrl_r.wdog_period_sel_hi, ctrl_r.wdog_period_sel_lo} <= `SUPV_CTRL_RST_SEL;
      end else if (ctrl_take) begin
         ctrl_r.protect_lock_enable_bit <= ctrl_wdata_i[`SUPV_CTRL_LOCK_BIT];
         if (!wp_r) begin
            ctrl_r.wdog_period_sel_hi <= ctrl_wdata_i[`SUPV_CTRL_SEL_HI];
            ctrl_r.wdog_period_sel_lo <= ctrl_wdata_i[`SUPV_CTRL_SEL_LO];
         end
      end
   end

   // running write is not cut by reset
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         nv_busy_r <= 1'b0;
         nv_cnt_r  <= 32'h0000_0000;
      end else if (ctrl_take || nv_take) begin
         nv_busy_r <= 1'b1;
         nv_cnt_r  <= 32'h0000_0000;
      end else if (nv_busy_r) begin
         if (last_cycle(nv_cnt_r, NV_WRITE_CYC)) begin
            nv_busy_r <= 1'b0;
         end
         nv_cnt_r <= nv_cnt_r + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_r      <= 1'b0;
         nv_start_r <= 1'b0;
      end else begin
         ack_r      <= ctrl_take;
         nv_start_r <= ctrl_take || nv_take;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin and bus gating outputs

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         oe_r <= !RESET_ACTIVE_HIGH;
      end else begin
         oe_r <= RESET_ACTIVE_HIGH ? (state_nxt == ST_RUN) : (state_nxt != ST_RUN);
      end
   end

   // abort on supply or watchdog reset
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         abort_r <= 1'b0;
      end else begin
         abort_r <= (state_r == ST_RUN) && (state_nxt != ST_RUN);
      end
   end

   assign rst_pin_o     = 1'b0;
   assign rst_pin_oe_o  = oe_r;
   // bus refused while reset is active
   assign bus_enable_o  = !hold;
   assign bus_abort_o   = abort_r;
   assign ctrl_wr_ack_o = ack_r;
   assign nv_start_o    = nv_start_r;
   assign nv_busy_o     = nv_busy_r;
   assign state_o       = state_r;

   always_comb begin
      ctrl_rdata_o                      = 8'h00;
      ctrl_rdata_o[`SUPV_CTRL_LOCK_BIT] = ctrl_r.protect_lock_enable_bit;
      ctrl_rdata_o[`SUPV_CTRL_SEL_HI]   = ctrl_r.wdog_period_sel_hi;
      ctrl_rdata_o[`SUPV_CTRL_SEL_LO]   = ctrl_r.wdog_period_sel_lo;
   end

endmodule

// [test/host_bus_model.sv]
`timescale 1ns/10ps
module host_bus_model (
   input  wire logic go_i,
   output logic      sda_o,
   output logic      scl_o
);
   // Released lines sit at the pull-up level
   initial begin
      sda_o = 1'b1;
      scl_o = 1'b1;
   end
   always @(posedge go_i) begin
      #150 sda_o = 1'b0;
      #150 scl_o = 1'b0;
      #100 sda_o = 1'b1;
      #50 scl_o = 1'b1;
   end
endmodule

// [test/supv_properties.sv]
`timescale 1ns/10ps
module supv_properties
   import supv_pkg::*;
#(
   parameter bit          RESET_ACTIVE_HIGH = 1'b0,
   parameter logic [31:0] RELEASE_CYC       = 40,
   parameter logic [31:0] POWERUP_CYC       = 50,
   parameter logic [31:0] NV_WRITE_CYC      = 20
)
(
   input wire logic       clk_i,
   input wire logic       rstn_i,
   input wire logic       supply_low_i,
   input wire logic       rst_pin_o,
   input wire logic       rst_pin_oe_o,
   input wire logic       bus_enable_o,
   input wire logic       bus_abort_o,
   input wire logic       nv_start_o,
   input wire logic       nv_busy_o,
   input wire logic [1:0] state_o
);
   logic [31:0] good_r;
   logic [31:0] busy_r;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // Cycles of good supply and of busy write
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         good_r <= '0;
         busy_r <= '0;
      end else begin
         good_r <= supply_low_i ? '0 : good_r + 1;
         busy_r <= nv_busy_o ? busy_r + 1 : '0;
      end
   end
   a_pin_open_drain: assert property (rst_pin_o == 1'b0)
      else $error("reset pin data not low");
   a_pin_polarity: assert property
      (rst_pin_oe_o == ((state_o != 2'b11) ^ RESET_ACTIVE_HIGH))
      else $error("reset pin enable wrong");
   a_low_supply_trip: assert property
      (($rose(supply_low_i) && state_o == 2'b11 ##1 supply_low_i [*2]) |=> state_o == 2'b01)
      else $error("low supply did not assert reset");
   a_release_hold: assert property
      (state_o == 2'b11 && $past(state_o) == 2'b01 |-> good_r inside {[RELEASE_CYC:RELEASE_CYC+4]})
      else $error("release delay wrong");
   a_powerup_hold: assert property
      (state_o == 2'b11 && $past(state_o) == 2'b00 |-> good_r inside {[POWERUP_CYC:POWERUP_CYC+4]})
      else $error("power-up delay wrong");
   a_abort_pulse: assert property
      (state_o != 2'b11 && $past(state_o) == 2'b11 |-> bus_abort_o ##1 !bus_abort_o)
      else $error("abort pulse missing");
   a_abort_cause: assert property (bus_abort_o |-> $past(state_o, 2) == 2'b11)
      else $error("abort without leaving run");
   a_bus_gate: assert property (bus_enable_o == (state_o == 2'b11))
      else $error("bus enable during reset");
   a_nv_gate: assert property
      (nv_start_o |-> $past(state_o) == 2'b11 && !$past(nv_busy_o))
      else $error("write started in reset");
   a_nv_finish: assert property ($fell(nv_busy_o) |-> busy_r == NV_WRITE_CYC)
      else $error("write cycle length wrong");
endmodule
bind supply_supervisor_watchdog_reset supv_properties #(
   .RESET_ACTIVE_HIGH(RESET_ACTIVE_HIGH), .RELEASE_CYC(RELEASE_CYC),
   .POWERUP_CYC(POWERUP_CYC), .NV_WRITE_CYC(NV_WRITE_CYC)
) supv_properties_inst (
   .clk_i(clk_i), .rstn_i(rstn_i), .supply_low_i(supply_low_i), .rst_pin_o(rst_pin_o),
   .rst_pin_oe_o(rst_pin_oe_o), .bus_enable_o(bus_enable_o), .bus_abort_o(bus_abort_o),
   .nv_start_o(nv_start_o), .nv_busy_o(nv_busy_o), .state_o(state_o)
);

// [test/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
   import supv_pkg::*;
   logic       clk_i, rstn_i, link_clk_i, supply_low_i, wp_i, ctrl_wr_i, nv_req_i, go;
   logic [7:0] ctrl_wdata_i, ctrl_rdata_o;
   logic       rst_pin_o, rst_pin_oe_o, bus_enable_o, nv_start_o, nv_busy_o, a;
   logic [1:0] state_o;
   wire        sda_w, scl_w;
   wire        rst_lvl = rst_pin_oe_o ? rst_pin_o : 1'b1;
   int         error_cnt, checks_done, n;
   // Shortened delays for simulation
   localparam logic [31:0] PUP_CYC  = 32'd50;
   localparam logic [31:0] REL_CYC  = 32'd40;
   localparam logic [31:0] WD_LONG  = 32'd400;
   localparam logic [31:0] WD_MID   = 32'd300;
   localparam logic [31:0] WD_SHORT = 32'd200;
   localparam logic [31:0] NVW_CYC  = 32'd20;
   supply_supervisor_watchdog_reset #(
      .RELEASE_CYC(REL_CYC), .POWERUP_CYC(PUP_CYC), .WDOG_LONG_CYC(WD_LONG),
      .WDOG_MID_CYC(WD_MID), .WDOG_SHORT_CYC(WD_SHORT), .NV_WRITE_CYC(NVW_CYC)
   ) supply_supervisor_watchdog_reset_inst (
      .clk_i(clk_i), .rstn_i(rstn_i), .link_clk_i(link_clk_i), .sda_i(sda_w), .scl_i(scl_w),
      .supply_low_i(supply_low_i), .wp_i(wp_i), .ctrl_wr_i(ctrl_wr_i),
      .ctrl_wdata_i(ctrl_wdata_i), .nv_req_i(nv_req_i), .rst_pin_o(rst_pin_o),
      .rst_pin_oe_o(rst_pin_oe_o), .bus_enable_o(bus_enable_o), .bus_abort_o(),
      .ctrl_wr_ack_o(a), .nv_start_o(nv_start_o), .nv_busy_o(nv_busy_o),
      .ctrl_rdata_o(ctrl_rdata_o), .state_o(state_o)
   );
   host_bus_model host_bus_model_inst (.go_i(go), .sda_o(sda_w), .scl_o(scl_w));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %0h seen %0h", s, exp, seen);
      end
   endtask
   task automatic wait_st(input logic [1:0] s, input int m);
      n = 0;
      while (state_o !== s && n < m) begin
         @(posedge clk_i);
         #1;
         n++;
      end
   endtask
   task automatic wr(input logic [7:0] d, output logic ack);
      // Let the pin synchronisers settle first
      repeat (2) @(posedge clk_i);
      ctrl_wdata_i <= d;
      ctrl_wr_i <= 1'b1;
      @(posedge clk_i);
      ctrl_wr_i <= 1'b0;
      #1;
      ack = a;
      repeat (25) @(posedge clk_i);
      #1;
   endtask
   task automatic kick();
      @(posedge clk_i);
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
   endtask
   task automatic t_ctrl();
      logic k;
      wr(8'he0, k);
      chk("ack", k, 1'b1);
      chk("rdata", ctrl_rdata_o, 8'he0);
      wp_i <= 1'b1;
      wr(8'h00, k);
      chk("locked ack", k, 1'b0);
      chk("locked rdata", ctrl_rdata_o, 8'he0);
      wp_i <= 1'b0;
      wr(8'h60, k);
      wp_i <= 1'b1;
      wr(8'h80, k);
      chk("frozen sel", ctrl_rdata_o, 8'he0);
      wp_i <= 1'b0;
      wr(8'h60, k);
      chk("unlocked", ctrl_rdata_o, 8'h60);
      $display("t_ctrl done");
   endtask
   task automatic t_wdog();
      int  lim[3] = '{WD_LONG, WD_MID, WD_SHORT};
      logic k;
      for (int i = 0; i < 3; i++) begin
         kick();
         wr({1'b0, i[1:0], 5'h00}, k);
         repeat (3) begin
            repeat (lim[i] / 2) @(posedge clk_i);
            kick();
         end
         #1;
         chk("fed", state_o, 2'b11);
         kick();
         @(negedge sda_w);
         wait_st(2'b10, lim[i] + 80);
         chk("expiry", n inside {[lim[i] + 24:lim[i] + 44]}, 1'b1);
         wait_st(2'b11, 80);
         chk("wd hold", n inside {[REL_CYC - 2:REL_CYC + 4]}, 1'b1);
         wr(8'h60, k);
      end
      repeat (500) @(posedge clk_i);
      #1;
      chk("disabled", state_o, 2'b11);
      $display("t_wdog done");
   endtask
   task automatic t_dip();
      logic k;
      @(posedge clk_i);
      nv_req_i <= 1'b1;
      @(posedge clk_i);
      nv_req_i <= 1'b0;
      supply_low_i <= 1'b1;
      wait_st(2'b01, 10);
      chk("busy kept", nv_busy_o, 1'b1);
      chk("pin", rst_lvl, 1'b0);
      // Write finished, so only reset can refuse
      repeat (NVW_CYC) @(posedge clk_i);
      wr(8'h00, k);
      chk("refused", k, 1'b0);
      chk("refused rdata", ctrl_rdata_o, 8'h60);
      nv_req_i <= 1'b1;
      @(posedge clk_i);
      nv_req_i <= 1'b0;
      #1;
      chk("no nv start", nv_busy_o, 1'b0);
      supply_low_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      supply_low_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      supply_low_i <= 1'b0;
      wait_st(2'b11, 100);
      chk("release", n inside {[REL_CYC:REL_CYC + 6]}, 1'b1);
      chk("kept", ctrl_rdata_o, 8'h60);
      $display("t_dip done");
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   initial begin
      link_clk_i = 1'b0;
      #7 forever #32 link_clk_i = ~link_clk_i;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      test_done();
   end
   initial begin
      {rstn_i, supply_low_i, wp_i, ctrl_wr_i, nv_req_i, go, ctrl_wdata_i} = '0;
      repeat (16) @(posedge clk_i);
      #1;
      chk("reset pin", rst_lvl, 1'b0);
      @(posedge clk_i);
      rstn_i <= 1'b1;
      wait_st(2'b11, 200);
      chk("powerup", n inside {[PUP_CYC:PUP_CYC + 8]}, 1'b1);
      t_ctrl();
      t_wdog();
      t_dip();
      test_done();
   end
endmodule
